// file: hw/sdram_timing_map.svh
/*
 Offsets, field positions and reset values of the SDRAM timing register set.
 Assumes APB byte addressing; every offset is word aligned.
*/
// Function
// - Read latency field, bits 3-1, resets to three cycles.
// - Bit 0 adds half a cycle; forced off for SDR and mobile DDR.
// - Write-to-strobe delay from bits 1-0, reset one.
// - Wait after mode register command from bits 6-0, reset two.
// - Activate-to-precharge minimum from bits 3-0, reset seven.
// - Same-bank activate spacing from bits 3-0, reset eleven.
// - Activate-to-column delay bits 2-0, scheduler copy 5-3, reset 0x1d.
// - Refresh interval bits 4-0, scheduler copy 9-5, reset 0x212.
// - Precharge-to-activate bits 2-0, scheduler copy 5-3, reset 0x1d.
// - Cross-bank activate spacing from bits 3-0, reset two.
// - Last write data to precharge minimum from bits 2-0, reset three.
`ifndef SDRAM_TIMING_MAP_SVH
`define SDRAM_TIMING_MAP_SVH

`define APB_ADDR_W 12
`define BANK_IDX_W 3
`define CNT_W 7

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_READ_LAT 12'h014
`define OFS_WR_STROBE 12'h018
`define OFS_MODE_CMD 12'h01c
`define OFS_ACT_PRE 12'h020
`define OFS_SAME_ACT 12'h024
`define OFS_ACT_COL 12'h028
`define OFS_REFRESH 12'h02c
`define OFS_PRE_ACT 12'h030
`define OFS_CROSS_ACT 12'h034
`define OFS_WR_RECOV 12'h038

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_READ_LAT 4'h6
`define RST_WR_STROBE 2'h1
`define RST_MODE_CMD 7'h02
`define RST_ACT_PRE 4'h7
`define RST_SAME_ACT 4'hb
`define RST_ACT_COL 6'h1d
`define RST_REFRESH 10'h212
`define RST_PRE_ACT 6'h1d
`define RST_CROSS_ACT 4'h2
`define RST_WR_RECOV 3'h3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LAT_HALF_BIT 0
`define LAT_CL_LO 1
`define LAT_CL_HI 3
`define DQSS_HI 1
`define MRD_HI 6
`define RAS_HI 3
`define RC_HI 3
`define RCD_HI 2
`define RCD_SCH_LO 3
`define RCD_SCH_HI 5
`define RFC_HI 4
`define RFC_SCH_LO 5
`define RFC_SCH_HI 9
`define RP_HI 2
`define RP_SCH_LO 3
`define RP_SCH_HI 5
`define RRD_HI 3
`define WR_HI 2

`define MTYPE_SDR 3'h0
`define MTYPE_LPDDR 3'h3

`endif

// file: hw/sdram_timing_pkg.sv
/*
 Types shared by the SDRAM timing register set and its sequencer.
 Assumes sdram_timing_map.svh is on the include path.
*/
`include "sdram_timing_map.svh"

package sdram_timing_pkg;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_PRE_ALL, CMD_REFRESH, CMD_MODE
   } cmd_kind_t;

   typedef struct packed {
      logic valid;
      cmd_kind_t kind;
      logic [`BANK_IDX_W-1:0] bank;
      logic wr_last;
      logic [`BANK_IDX_W-1:0] wr_bank;
   } seq_cmd_t;

   typedef struct packed {
      logic [`LAT_CL_HI-`LAT_CL_LO:0] read_lat;
      logic half_cycle;
      logic [`DQSS_HI:0] wr_strobe;
      logic [`MRD_HI:0] mode_cmd;
      logic [`RAS_HI:0] act_pre;
      logic [`RC_HI:0] same_act;
      logic [`RCD_HI:0] act_col;
      logic [`RCD_SCH_HI-`RCD_SCH_LO:0] act_col_sched;
      logic [`RFC_HI:0] refresh;
      logic [`RFC_SCH_HI-`RFC_SCH_LO:0] refresh_sched;
      logic [`RP_HI:0] pre_act;
      logic [`RP_SCH_HI-`RP_SCH_LO:0] pre_act_sched;
      logic [`RRD_HI:0] cross_act;
      logic [`WR_HI:0] wr_recov;
   } timing_cfg_t;

endpackage : sdram_timing_pkg

// file: hw/sdram_timing_parameter_regs.sv
/*
 SDRAM timing parameter registers on APB, with the command spacing gates
 that the sequencer obeys.
 Assumes the sequencer issues a command only when its gate is high, and
 that software programs the set only in config or low-power state.
*/
`timescale 1ns/100ps
`default_nettype none

module sdram_timing_parameter_regs
   import sdram_timing_pkg::*;
#(
   parameter int NUM_BANKS = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output var logic [31:0] prdata,
   output var logic pready,
   output var logic pslverr,
   input wire logic [2:0] mem_type,
   input wire seq_cmd_t seq_cmd,
   output var timing_cfg_t timing,
   output var logic [NUM_BANKS-1:0] act_ok,
   output var logic [NUM_BANKS-1:0] col_ok,
   output var logic [NUM_BANKS-1:0] pre_ok,
   output var logic mode_ok
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef logic [`CNT_W-1:0] cnt_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [`LAT_CL_HI:0] lat;
      logic [`DQSS_HI:0] dqss;
      logic [`MRD_HI:0] mrd;
      logic [`RAS_HI:0] ras;
      logic [`RC_HI:0] rc;
      logic [`RCD_SCH_HI:0] rcd;
      logic [`RFC_SCH_HI:0] rfc;
      logic [`RP_SCH_HI:0] rp;
      logic [`RRD_HI:0] rrd;
      logic [`WR_HI:0] wr;
      logic half_eff;
      logic [NUM_BANKS-1:0][`CNT_W-1:0] ras_c;
      logic [NUM_BANKS-1:0][`CNT_W-1:0] rc_c;
      logic [NUM_BANKS-1:0][`CNT_W-1:0] rcd_c;
      logic [NUM_BANKS-1:0][`CNT_W-1:0] rp_c;
      logic [NUM_BANKS-1:0][`CNT_W-1:0] wr_c;
      cnt_t rrd_c;
      cnt_t mrd_c;
      cnt_t rfc_c;
      logic [NUM_BANKS-1:0] act_ok;
      logic [NUM_BANKS-1:0] col_ok;
      logic [NUM_BANKS-1:0] pre_ok;
      logic mode_ok;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Load n-1 so the dependent command may follow n edges later
   function automatic cnt_t load_cnt(input cnt_t n);
      load_cnt = (n == '0) ? '0 : n - 1'b1;
   endfunction : load_cnt

   function automatic cnt_t step_cnt(input cnt_t c);
      step_cnt = (c == '0) ? '0 : c - 1'b1;
   endfunction : step_cnt

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge = m;
   endfunction : merge

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   logic setup_ph;
   logic access_ph;
   logic hit;
   logic [31:0] rd_word;
   logic [31:0] cur_word;
   logic [31:0] wr_word;
   logic [`BANK_IDX_W-1:0] cb;
   logic [`BANK_IDX_W-1:0] wb;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & st_r.ready;
   assign cb = seq_cmd.bank;
   assign wb = seq_cmd.wr_bank;

   // Reserved bits read as zero
   always_comb begin
      hit = 1'b1;
      rd_word = '0;
      case (paddr)
         `OFS_READ_LAT: rd_word[`LAT_CL_HI:0] = st_r.lat;
         `OFS_WR_STROBE: rd_word[`DQSS_HI:0] = st_r.dqss;
         `OFS_MODE_CMD: rd_word[`MRD_HI:0] = st_r.mrd;
         `OFS_ACT_PRE: rd_word[`RAS_HI:0] = st_r.ras;
         `OFS_SAME_ACT: rd_word[`RC_HI:0] = st_r.rc;
         `OFS_ACT_COL: rd_word[`RCD_SCH_HI:0] = st_r.rcd;
         `OFS_REFRESH: rd_word[`RFC_SCH_HI:0] = st_r.rfc;
         `OFS_PRE_ACT: rd_word[`RP_SCH_HI:0] = st_r.rp;
         `OFS_CROSS_ACT: rd_word[`RRD_HI:0] = st_r.rrd;
         `OFS_WR_RECOV: rd_word[`WR_HI:0] = st_r.wr;
         default: hit = 1'b0;
      endcase
   end

   assign cur_word = rd_word;
   assign wr_word = merge(cur_word, pwdata, pstrb);

   always_comb begin
      st_nxt = st_r;

      // APB: ready registered from setup, so with clk_en high every access completes with no wait state
      st_nxt.ready = 1'b0;
      if (setup_ph) begin
         st_nxt.ready = 1'b1;
         st_nxt.err = ~hit;
         st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_word;
      end
      if (access_ph && pwrite && hit) begin
         case (paddr)
            `OFS_READ_LAT: st_nxt.lat = wr_word[`LAT_CL_HI:0];
            `OFS_WR_STROBE: st_nxt.dqss = wr_word[`DQSS_HI:0];
            `OFS_MODE_CMD: st_nxt.mrd = wr_word[`MRD_HI:0];
            `OFS_ACT_PRE: st_nxt.ras = wr_word[`RAS_HI:0];
            `OFS_SAME_ACT: st_nxt.rc = wr_word[`RC_HI:0];
            `OFS_ACT_COL: st_nxt.rcd = wr_word[`RCD_SCH_HI:0];
            `OFS_REFRESH: st_nxt.rfc = wr_word[`RFC_SCH_HI:0];
            `OFS_PRE_ACT: st_nxt.rp = wr_word[`RP_SCH_HI:0];
            `OFS_CROSS_ACT: st_nxt.rrd = wr_word[`RRD_HI:0];
            `OFS_WR_RECOV: st_nxt.wr = wr_word[`WR_HI:0];
            default: ;
         endcase
      end

      // Half-cycle offset is meaningless without a DDR strobe
      st_nxt.half_eff = st_nxt.lat[`LAT_HALF_BIT];
      if (mem_type == `MTYPE_SDR || mem_type == `MTYPE_LPDDR) begin
         st_nxt.half_eff = 1'b0;
      end

      // Free-running decrement of every spacing counter
      for (int b = 0; b < NUM_BANKS; b++) begin
         st_nxt.ras_c[b] = step_cnt(st_r.ras_c[b]);
         st_nxt.rc_c[b] = step_cnt(st_r.rc_c[b]);
         st_nxt.rcd_c[b] = step_cnt(st_r.rcd_c[b]);
         st_nxt.rp_c[b] = step_cnt(st_r.rp_c[b]);
         st_nxt.wr_c[b] = step_cnt(st_r.wr_c[b]);
      end
      st_nxt.rrd_c = step_cnt(st_r.rrd_c);
      st_nxt.mrd_c = step_cnt(st_r.mrd_c);
      st_nxt.rfc_c = step_cnt(st_r.rfc_c);

      // Loads use the values in force before this cycle's register write
      if (seq_cmd.valid) begin
         case (seq_cmd.kind)
            CMD_ACT: begin
               for (int b = 0; b < NUM_BANKS; b++) begin
                  if (cb == `BANK_IDX_W'(b)) begin
                     st_nxt.ras_c[b] = load_cnt(`CNT_W'(st_r.ras));
                     st_nxt.rc_c[b] = load_cnt(`CNT_W'(st_r.rc));
                     st_nxt.rcd_c[b] = load_cnt(`CNT_W'(st_r.rcd[`RCD_HI:0]));
                  end
               end
               st_nxt.rrd_c = load_cnt(`CNT_W'(st_r.rrd));
            end
            CMD_PRE: begin
               for (int b = 0; b < NUM_BANKS; b++) begin
                  if (cb == `BANK_IDX_W'(b)) begin
                     st_nxt.rp_c[b] = load_cnt(`CNT_W'(st_r.rp[`RP_HI:0]));
                  end
               end
            end
            CMD_PRE_ALL: begin
               for (int b = 0; b < NUM_BANKS; b++) begin
                  st_nxt.rp_c[b] = load_cnt(`CNT_W'(st_r.rp[`RP_HI:0]));
               end
            end
            CMD_REFRESH: begin
               st_nxt.rfc_c = load_cnt(`CNT_W'(st_r.rfc[`RFC_HI:0]));
            end
            CMD_MODE: begin
               st_nxt.mrd_c = load_cnt(st_r.mrd);
            end
            default: ;
         endcase
      end
      if (seq_cmd.wr_last) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            if (wb == `BANK_IDX_W'(b)) begin
               st_nxt.wr_c[b] = load_cnt(`CNT_W'(st_r.wr));
            end
         end
      end

      // Gates registered from the next counter values
      st_nxt.mode_ok = (st_nxt.mrd_c == '0) && (st_nxt.rfc_c == '0);
      for (int b = 0; b < NUM_BANKS; b++) begin
         st_nxt.act_ok[b] = st_nxt.mode_ok && (st_nxt.rc_c[b] == '0) &&
                            (st_nxt.rp_c[b] == '0) && (st_nxt.rrd_c == '0);
         st_nxt.col_ok[b] = st_nxt.mode_ok && (st_nxt.rcd_c[b] == '0);
         st_nxt.pre_ok[b] = st_nxt.mode_ok && (st_nxt.ras_c[b] == '0) &&
                            (st_nxt.wr_c[b] == '0);
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.lat <= `RST_READ_LAT;
         st_r.dqss <= `RST_WR_STROBE;
         st_r.mrd <= `RST_MODE_CMD;
         st_r.ras <= `RST_ACT_PRE;
         st_r.rc <= `RST_SAME_ACT;
         st_r.rcd <= `RST_ACT_COL;
         st_r.rfc <= `RST_REFRESH;
         st_r.rp <= `RST_PRE_ACT;
         st_r.rrd <= `RST_CROSS_ACT;
         st_r.wr <= `RST_WR_RECOV;
         st_r.act_ok <= '1;
         st_r.col_ok <= '1;
         st_r.pre_ok <= '1;
         st_r.mode_ok <= 1'b1;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all flop fields
   // ----------------------------------------------------------------------
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign act_ok = st_r.act_ok;
   assign col_ok = st_r.col_ok;
   assign pre_ok = st_r.pre_ok;
   assign mode_ok = st_r.mode_ok;

   assign timing.read_lat = st_r.lat[`LAT_CL_HI:`LAT_CL_LO];
   assign timing.half_cycle = st_r.half_eff;
   assign timing.wr_strobe = st_r.dqss;
   assign timing.mode_cmd = st_r.mrd;
   assign timing.act_pre = st_r.ras;
   assign timing.same_act = st_r.rc;
   assign timing.act_col = st_r.rcd[`RCD_HI:0];
   assign timing.act_col_sched = st_r.rcd[`RCD_SCH_HI:`RCD_SCH_LO];
   assign timing.refresh = st_r.rfc[`RFC_HI:0];
   assign timing.refresh_sched = st_r.rfc[`RFC_SCH_HI:`RFC_SCH_LO];
   assign timing.pre_act = st_r.rp[`RP_HI:0];
   assign timing.pre_act_sched = st_r.rp[`RP_SCH_HI:`RP_SCH_LO];
   assign timing.cross_act = st_r.rrd;
   assign timing.wr_recov = st_r.wr;

endmodule : sdram_timing_parameter_regs

`default_nettype wire

// file: verification/timing_regs_assertions.sv
/* Checker for the timing register set: command gates and half-cycle forcing.
 Bound to the top module from the testbench; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
`include "sdram_timing_map.svh"
module timing_regs_assertions
   import sdram_timing_pkg::*;
#(
   parameter int NUM_BANKS = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [2:0] mem_type,
   input wire seq_cmd_t seq_cmd,
   input wire timing_cfg_t timing,
   input wire logic [NUM_BANKS-1:0] act_ok,
   input wire logic [NUM_BANKS-1:0] col_ok,
   input wire logic [NUM_BANKS-1:0] pre_ok,
   input wire logic mode_ok
);
   // ----------------------------------------------------------------
   // Gate and half-cycle properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic cmd = clk_en && seq_cmd.valid;
   wire logic act0 = cmd && seq_cmd.kind == CMD_ACT && seq_cmd.bank == 3'h0;
   property p_half; clk_en && (mem_type == `MTYPE_SDR || mem_type == `MTYPE_LPDDR)
      |=> !timing.half_cycle; endproperty
   a_half: assert property (p_half) else $error("half cycle not forced off");
   property p_mode; cmd && seq_cmd.kind == CMD_MODE && timing.mode_cmd > 7'h01 |=> !mode_ok;
   endproperty
   a_mode: assert property (p_mode) else $error("mode gate open too soon");
   property p_ras; act0 && timing.act_pre > 4'h1 |=> !pre_ok[0]; endproperty
   a_ras: assert property (p_ras) else $error("precharge gate open too soon");
   property p_rc; act0 && timing.same_act > 4'h1 |=> !act_ok[0]; endproperty
   a_rc: assert property (p_rc) else $error("same bank gate open too soon");
   property p_rcd; act0 && timing.act_col == 3'h3 |=> !col_ok[0] [*2]; endproperty
   a_rcd: assert property (p_rcd) else $error("column gate open too soon");
   property p_rfc; cmd && seq_cmd.kind == CMD_REFRESH && timing.refresh > 5'h01
      |=> !mode_ok && !act_ok[1]; endproperty
   a_rfc: assert property (p_rfc) else $error("refresh gate open too soon");
   property p_rp; cmd && seq_cmd.kind == CMD_PRE && seq_cmd.bank == 3'h2
      && timing.pre_act > 3'h1 |=> !act_ok[2]; endproperty
   a_rp: assert property (p_rp) else $error("activate gate open after precharge");
   property p_rrd; act0 && timing.cross_act > 4'h1 |=> !act_ok[1]; endproperty
   a_rrd: assert property (p_rrd) else $error("cross bank gate open too soon");
   property p_wr; clk_en && seq_cmd.wr_last && seq_cmd.wr_bank == 3'h0
      && timing.wr_recov > 3'h1 |=> !pre_ok[0]; endproperty
   a_wr: assert property (p_wr) else $error("write recovery gate open too soon");
   c_act: cover property (act0);
   c_mode: cover property (cmd && seq_cmd.kind == CMD_MODE);
   c_col: cover property ($fell(col_ok[0]));
endmodule : timing_regs_assertions
`default_nettype wire

// file: verification/seq_issuer.sv
/* Command sequencer stand-in: issues one requested command once its gate opens.
 Assumes the testbench holds the request until it sees the command go out. */
`timescale 1ns/100ps
`default_nettype none
module seq_issuer
   import sdram_timing_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic req_v,
   input wire cmd_kind_t req_kind,
   input wire logic [2:0] req_bank,
   input wire logic [3:0] act_ok,
   input wire logic [3:0] col_ok,
   input wire logic [3:0] pre_ok,
   input wire logic mode_ok,
   output var seq_cmd_t seq_cmd
);
   logic ok;
   always_comb begin
      case (req_kind)
         CMD_ACT: ok = act_ok[req_bank[1:0]];
         CMD_READ, CMD_WRITE: ok = col_ok[req_bank[1:0]];
         CMD_PRE: ok = pre_ok[req_bank[1:0]];
         default: ok = mode_ok && &act_ok && &pre_ok;
      endcase
   end
   // Never issues against a closed gate, so every interval is honoured
   always_ff @(posedge core_clk) begin
      seq_cmd <= '0;
      if (rst_b && req_v && !seq_cmd.valid && ok) begin
         seq_cmd.valid <= 1'b1;
         seq_cmd.kind <= req_kind;
         seq_cmd.bank <= req_bank;
         seq_cmd.wr_last <= (req_kind == CMD_WRITE);
         seq_cmd.wr_bank <= req_bank;
      end
   end
endmodule : seq_issuer
`default_nettype wire

// file: verification/testbench.sv
/* Self-checking bench: APB register model and measured command gate intervals.
 Assumes the design answers APB with no wait state; clk_en held high. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sdram_timing_pkg::*;
   logic core_clk = 0, rst_b = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v;
   logic [3:0] pstrb = 4'h0, act_ok, col_ok, pre_ok;
   logic pready, pslverr, mode_ok, er, req_v = 0;
   logic [2:0] mem_type = 3'h0, req_bank = 3'h0;
   cmd_kind_t req_kind = CMD_NOP;
   seq_cmd_t seq_cmd;
   timing_cfg_t timing;
   int fail_count = 0, n_tests = 0, seed = 18432, i, j, k, n, e;
   logic [31:0] m[10];
   logic [31:0] rst_v[10] = '{32'h6, 32'h1, 32'h2, 32'h7, 32'hb, 32'h1d, 32'h212, 32'h1d,
      32'h2, 32'h3};
   logic [31:0] rmask[10] = '{32'hf, 32'h3, 32'h7f, 32'hf, 32'hf, 32'h3f, 32'h3ff, 32'h3f,
      32'hf, 32'h7};
   cmd_kind_t t_kind[7] = '{CMD_ACT, CMD_ACT, CMD_ACT, CMD_PRE, CMD_MODE, CMD_REFRESH,
      CMD_WRITE};
   int t_gate[7] = '{0, 1, 2, 3, 4, 4, 1};
   int t_reg[7] = '{5, 3, 8, 7, 2, 6, 9};
   logic [31:0] t_fm[7] = '{32'h7, 32'hf, 32'hf, 32'h7, 32'h7f, 32'h1f, 32'h7};
   sdram_timing_parameter_regs #(.NUM_BANKS(4)) sdram_timing_parameter_regs_inst (.core_clk,
      .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .mem_type, .seq_cmd, .timing, .act_ok, .col_ok, .pre_ok, .mode_ok);
   seq_issuer seq_issuer_inst (.core_clk, .rst_b, .req_v, .req_kind, .req_bank, .act_ok,
      .col_ok, .pre_ok, .mode_ok, .seq_cmd);
   initial forever #50 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         fail_count++;
         $display("[FAIL] %0t: got %h expected %h", $time, s, x);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int x;
      x = (a - 12'h014) / 4;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
      rd = prdata; er = pslverr;
      // Idle edge keeps the next setup from re-driving psel in this time step
      psel <= 1'b0; penable <= 1'b0;
      @(posedge core_clk);
      if (a >= 12'h014 && a <= 12'h038 && a[1:0] == 2'h0) begin
         if (w) for (int b = 0; b < 4; b++) if (s[b]) m[x][8*b+:8] = d[8*b+:8];
         m[x] = m[x] & rmask[x];
         chk({31'h0, er}, 32'h0);
         if (!w) chk(rd, m[x]);
      end else begin
         chk({31'h0, er}, 32'h1);
         chk(rd, 32'h0);
      end
   endtask : apb
   task fields;
      @(posedge core_clk);
      chk(timing.read_lat, m[0][3:1]);
      chk(timing.wr_strobe, m[1][1:0]);
      chk(timing.act_col_sched, m[5][5:3]);
      chk(timing.refresh_sched, m[6][9:5]);
      chk(timing.pre_act_sched, m[7][5:3]);
      chk(timing.mode_cmd, m[2][6:0]);
      chk(timing.act_pre, m[3][3:0]);
      chk(timing.same_act, m[4][3:0]);
      chk(timing.act_col, m[5][2:0]);
      chk(timing.refresh, m[6][4:0]);
      chk(timing.pre_act, m[7][2:0]);
      chk(timing.cross_act, m[8][3:0]);
      chk(timing.wr_recov, m[9][2:0]);
      for (i = 0; i < 4; i++) begin
         mem_type <= i[2:0];
         repeat (2) @(posedge core_clk);
         chk(timing.half_cycle, (i == 0 || i == 3) ? 1'b0 : m[0][0]);
      end
   endtask : fields
   function logic gate(input int g);
      case (g)
         0: return col_ok[0];
         1: return pre_ok[0];
         2: return act_ok[1];
         3: return act_ok[0];
         default: return mode_ok;
      endcase
   endfunction : gate
   task results;
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      #2000000;
      fail_count++;
      results();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 10; i++) m[i] = rst_v[i];
      for (i = 0; i < 10; i++) apb(1'b0, 12'h014 + 12'(4 * i), 32'h0, 4'h0);
      fields();
      $display("test reset_values done");
      for (j = 0; j < 10; j++) apb(1'b1, 12'h014 + 12'(4 * j), $random(seed), $random(seed));
      for (j = 0; j < 10; j++) apb(1'b0, 12'h014 + 12'(4 * j), 32'h0, 4'h0);
      fields();
      apb(1'b1, 12'h03c, 32'hffffffff, 4'hf);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      $display("test register_access done");
      for (j = 0; j < 7; j++) begin
         apb(1'b1, 12'h014 + 12'(4 * t_reg[j]), $random(seed), 4'hf);
         n = int'(m[t_reg[j]] & t_fm[j]);
         e = (n == 0) ? 0 : n - 1;
         k = 0;
         while (!(&act_ok && &col_ok && &pre_ok && mode_ok) && k < 300) begin
            @(posedge core_clk);
            k++;
         end
         req_kind <= t_kind[j]; req_bank <= 3'h0; req_v <= 1'b1;
         k = 0;
         do begin @(posedge core_clk); k++; end while (seq_cmd.valid !== 1'b1 && k < 300);
         req_v <= 1'b0;
         n = 0;
         @(posedge core_clk);
         while (gate(t_gate[j]) !== 1'b1 && n < 300) begin
            n++;
            @(posedge core_clk);
         end
         chk(n, e);
         $display("test gate %0d done", j);
      end
      results();
   end
endmodule : testbench
bind sdram_timing_parameter_regs timing_regs_assertions #(.NUM_BANKS(NUM_BANKS)) chk_inst (
   .core_clk, .rst_b, .clk_en, .mem_type, .seq_cmd, .timing, .act_ok, .col_ok, .pre_ok,
   .mode_ok);
`default_nettype wire
